/* src/dfro_pkg.sv */
// Package with register map, field positions and encodings for the decrement-register block.
package dfro_pkg;
  localparam int unsigned ADDR_W        = 12;
  localparam int unsigned APB_AW        = 8;
  // Register byte offsets.
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_OPCODE    = 8'h04;
  localparam logic [7:0]  OFS_BANK      = 8'h08;
  localparam logic [7:0]  OFS_INDEX     = 8'h0C;
  localparam logic [7:0]  OFS_WORK      = 8'h10;
  localparam logic [7:0]  OFS_STATUS    = 8'h14;
  localparam logic [7:0]  OFS_MEMADDR   = 8'h18;
  localparam logic [7:0]  OFS_MEMDATA   = 8'h1C;
  // Field positions.
  localparam int unsigned CTRL_START    = 0;
  localparam int unsigned CTRL_EXT_EN   = 1;
  localparam int unsigned ST_CARRY      = 0;
  localparam int unsigned ST_HALF       = 1;
  localparam int unsigned ST_ZERO       = 2;
  localparam int unsigned ST_OVF        = 3;
  localparam int unsigned ST_NEG        = 4;
  localparam int unsigned ST_BUSY       = 8;
  localparam int unsigned ST_BAD_OP     = 9;
  localparam int unsigned OP_DEST       = 9;
  localparam int unsigned OP_ACCESS     = 8;
  // Opcode family: upper six bits of the decrement-register instruction.
  localparam logic [5:0]  OP_DECR_CODE  = 6'h01;
  // Access-bank split and the bank that holds the upper access half.
  localparam logic [7:0]  ACC_LOW_MAX   = 8'h5F;
  localparam logic [3:0]  ACC_HIGH_BANK = 4'hF;
  // Reset values.
  localparam logic [15:0] RST_OPCODE    = 16'h0600;
  localparam logic [7:0]  RST_WORK      = 8'h00;
  localparam logic [4:0]  RST_FLAGS     = 5'h00;
  localparam logic [3:0]  RST_BANK      = 4'h0;
  localparam logic [11:0] RST_INDEX     = 12'h000;
  typedef enum logic [2:0] {DFRO_IDLE, DFRO_Q1, DFRO_Q2, DFRO_Q3, DFRO_Q4} dfro_state_t;
endpackage

/* src/dfro_dec_alu.sv */
// Combinational 8-bit decrement with status flag generation.
`timescale 1ns/100ps
module dfro_dec_alu (
  input  wire logic [7:0] operand_i,
  output logic      [7:0] result_o,
  output logic            carry_o,
  output logic            half_carry_flag_o,
  output logic            zero_o,
  output logic            signed_overflow_flag_o,
  output logic            neg_o
);
  // Subtraction is done as adding all-ones, so carry means no borrow.
  logic [8:0] sum;
  logic [4:0] low_sum;
  assign sum                    = {1'h0, operand_i} + 9'h0FF;
  assign low_sum                = {1'h0, operand_i[3:0]} + 5'h0F;
  assign result_o               = sum[7:0];
  assign carry_o                = sum[8];
  assign half_carry_flag_o      = low_sum[4];
  assign zero_o                 = (sum[7:0] == 8'h00);
  assign signed_overflow_flag_o = (operand_i == 8'h80);
  assign neg_o                  = sum[7];
endmodule

/* src/dfro_top.sv */
// Decrement-register instruction executor with data memory, reached over APB.
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/100ps
module dfro_top
  import dfro_pkg::*;
(
  input  wire logic                      clk_sys_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      ce_i,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [dfro_pkg::APB_AW-1:0] paddr_i,
  input  wire logic [31:0]               pwdata_i,
  output logic      [31:0]               prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  output logic                           busy_o
);
  import dfro_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0]        mem [0:(1<<ADDR_W)-1];
  dfro_state_t       state_q;
  logic [15:0]       opcode_q;
  logic [7:0]        work_q;
  logic [4:0]        flags_q;
  logic              ext_en_q;
  logic              bad_op_q;
  logic [3:0]        bank_q;
  logic [11:0]       index_q;
  logic [11:0]       memaddr_q;
  logic [ADDR_W-1:0] ea_q;
  logic [7:0]        src_q;
  logic [7:0]        res_q;
  logic [4:0]        res_flags_q;
  logic              pready_q;
  logic              pslverr_q;
  logic [31:0]       prdata_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode. A write while an instruction runs is refused so that software
  // never races the sequencer on the opcode, work register or memory.
  wire         busy      = (state_q != DFRO_IDLE);
  wire         acc_st    = psel_i & penable_i & ~pready_q;
  wire         acc_done  = psel_i & penable_i & pready_q;
  wire         hit_ctrl  = (paddr_i == OFS_CTRL);
  wire         hit_op    = (paddr_i == OFS_OPCODE);
  wire         hit_bank  = (paddr_i == OFS_BANK);
  wire         hit_index = (paddr_i == OFS_INDEX);
  wire         hit_work  = (paddr_i == OFS_WORK);
  wire         hit_stat  = (paddr_i == OFS_STATUS);
  wire         hit_maddr = (paddr_i == OFS_MEMADDR);
  wire         hit_mdata = (paddr_i == OFS_MEMDATA);
  wire         mapped    = hit_ctrl | hit_op | hit_bank | hit_index | hit_work |
                           hit_stat | hit_maddr | hit_mdata;
  wire         refuse    = ~mapped | (pwrite_i & busy);
  wire         wr_ok     = acc_done & pwrite_i & ~pslverr_q;
  wire         start     = wr_ok & hit_ctrl & pwdata_i[CTRL_START];
  wire [31:0]  status_rd = {22'h0, bad_op_q, busy, 3'h0, flags_q};
  wire [31:0]  rd_mux    =
    hit_ctrl  ? {30'h0, ext_en_q, 1'h0} :
    hit_op    ? {16'h0, opcode_q} :
    hit_bank  ? {28'h0, bank_q} :
    hit_index ? {20'h0, index_q} :
    hit_work  ? {24'h0, work_q} :
    hit_stat  ? status_rd :
    hit_maddr ? {20'h0, memaddr_q} :
    hit_mdata ? {24'h0, mem[memaddr_q[ADDR_W-1:0]]} : 32'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Effective address of the operand.
  function automatic logic [ADDR_W-1:0] eff_addr(input logic [15:0] op,
                                                 input logic        ext,
                                                 input logic [3:0]  bank,
                                                 input logic [11:0] idx);
    logic [7:0] f;
    f = op[7:0];
    if (op[OP_ACCESS]) begin
      eff_addr = {bank, f};
    end else if (f <= ACC_LOW_MAX) begin
      eff_addr = ext ? idx + {4'h0, f} : {4'h0, f};
    end else begin
      eff_addr = {ACC_HIGH_BANK, f};
    end
  endfunction

  wire               op_legal = (opcode_q[15:10] == OP_DECR_CODE);
  wire [ADDR_W-1:0]  ea_d     = eff_addr(opcode_q, ext_en_q, bank_q, index_q);
  wire               dest_f   = opcode_q[OP_DEST];
  logic [7:0]        alu_res;
  logic              alu_c;
  logic              alu_dc;
  logic              alu_z;
  logic              alu_ov;
  logic              alu_n;

  dfro_dec_alu u_alu (
    .operand_i              (src_q),
    .result_o               (alu_res),
    .carry_o                (alu_c),
    .half_carry_flag_o      (alu_dc),
    .zero_o                 (alu_z),
    .signed_overflow_flag_o (alu_ov),
    .neg_o                  (alu_n)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, answer data and error captured with pready.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pready_q  <= 1'h0;
      pslverr_q <= 1'h0;
      prdata_q  <= 32'h0;
    end else if (ce_i) begin
      pready_q  <= acc_st;
      if (acc_st) begin
        pslverr_q <= refuse;
        prdata_q  <= (pwrite_i | ~mapped) ? 32'h0 : rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Software-visible configuration registers.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ext_en_q  <= 1'h0;
      opcode_q  <= RST_OPCODE;
      bank_q    <= RST_BANK;
      index_q   <= RST_INDEX;
      memaddr_q <= 12'h000;
    end else if (ce_i && wr_ok) begin
      if (hit_ctrl)  ext_en_q  <= pwdata_i[CTRL_EXT_EN];
      if (hit_op)    opcode_q  <= pwdata_i[15:0];
      if (hit_bank)  bank_q    <= pwdata_i[3:0];
      if (hit_index) index_q   <= pwdata_i[11:0];
      if (hit_maddr) memaddr_q <= pwdata_i[11:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction sequencer, one state per phase.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_q     <= DFRO_IDLE;
      bad_op_q    <= 1'h0;
      ea_q        <= '0;
      src_q       <= 8'h00;
      res_q       <= 8'h00;
      res_flags_q <= RST_FLAGS;
    end else if (ce_i) begin
      case (state_q)
        DFRO_IDLE: begin
          if (start) begin
            state_q <= DFRO_Q1;
          end
        end
        DFRO_Q1: begin
          bad_op_q <= ~op_legal;
          ea_q     <= ea_d;
          state_q  <= op_legal ? DFRO_Q2 : DFRO_IDLE;
        end
        DFRO_Q2: begin
          src_q   <= mem[ea_q];
          state_q <= DFRO_Q3;
        end
        DFRO_Q3: begin
          res_q       <= alu_res;
          res_flags_q <= {alu_n, alu_ov, alu_z, alu_dc, alu_c};
          state_q     <= DFRO_Q4;
        end
        DFRO_Q4: begin
          state_q <= DFRO_IDLE;
        end
        default: begin
          state_q <= DFRO_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Destination write in the last phase; flags and W are also software-writable.
  wire q4 = (state_q == DFRO_Q4);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      work_q  <= RST_WORK;
      flags_q <= RST_FLAGS;
    end else if (ce_i) begin
      if (q4) begin
        flags_q <= res_flags_q;
        if (!dest_f) begin
          work_q <= res_q;
        end
      end else if (wr_ok && hit_work) begin
        work_q <= pwdata_i[7:0];
      end else if (wr_ok && hit_stat) begin
        flags_q <= pwdata_i[4:0];
      end
    end
  end

  // Memory has no reset; its contents are loaded by software.
  always_ff @(posedge clk_sys_i) begin
    if (ce_i) begin
      if (q4 && dest_f) begin
        mem[ea_q] <= res_q;
      end else if (wr_ok && hit_mdata) begin
        mem[memaddr_q[ADDR_W-1:0]] <= pwdata_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'h0;
    end else if (ce_i) begin
      busy_o <= start | (busy & ~q4 & ~(state_q == DFRO_Q1 & ~op_legal));
    end
  end

  assign prdata_o  = prdata_q;
  assign pready_o  = pready_q;
  assign pslverr_o = pslverr_q;
endmodule

/* sim/dfro_checker.sv */
// Concurrent checks on the APB answer and the instruction busy window.
`timescale 1ns/100ps
module dfro_checker
  import dfro_pkg::*;
(
  input wire logic                         clk_sys_i,
  input wire logic                         rst_n_i,
  input wire logic                         ce_i,
  input wire logic                         psel_i,
  input wire logic                         penable_i,
  input wire logic                         pwrite_i,
  input wire logic [dfro_pkg::APB_AW-1:0] paddr_i,
  input wire logic [31:0]                  pwdata_i,
  input wire logic [31:0]                  prdata_o,
  input wire logic                         pready_o,
  input wire logic                         pslverr_o,
  input wire logic                         busy_o
);
  import dfro_pkg::*;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  a_ready_wait: assert property (ce_i && psel_i && penable_i && !pready_o ##1 ce_i |-> pready_o)
    else $error("ready missing one cycle into access");
  a_ready_pulse: assert property (ce_i && pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  a_ready_cause: assert property (pready_o |-> $past(psel_i && penable_i))
    else $error("ready without an access phase");
  a_unmapped_err: assert property (ce_i && psel_i && penable_i && !pready_o &&
    (paddr_i > OFS_MEMDATA || paddr_i[1:0] != 2'h0) |=> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped access not refused");
  a_start_busy: assert property (ce_i && pready_o && !pslverr_o && pwrite_i &&
    paddr_i == OFS_CTRL && pwdata_i[CTRL_START] |=> busy_o)
    else $error("start did not raise busy");
  a_busy_cause: assert property ($rose(busy_o) |-> $past(pready_o && pwrite_i))
    else $error("busy rose without a write");
  a_busy_run: assert property ($rose(busy_o) && ce_i ##1 busy_o && ce_i
    ##1 ce_i ##1 ce_i |-> busy_o && $past(busy_o) ##1 !busy_o)
    else $error("instruction not four cycles long");
  a_busy_refuse: assert property (ce_i && busy_o && psel_i && penable_i && pwrite_i &&
    !pready_o ##1 busy_o |-> pready_o && pslverr_o)
    else $error("write while busy not refused");
endmodule

bind dfro_top dfro_checker u_chk (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .busy_o(busy_o)
);

/* sim/dfro_top_tb_top.sv */
// Self-checking bench for the decrement-register block.
`timescale 1ns/100ps
module dfro_top_tb_top;
  import dfro_pkg::*;
  logic              clk_sys_i = 1'h0;
  logic              rst_n_i   = 1'h0;
  logic              ce_i      = 1'h1;
  logic              psel_i    = 1'h0;
  logic              penable_i = 1'h0;
  logic              pwrite_i  = 1'h0;
  logic [APB_AW-1:0] paddr_i   = 8'h0;
  logic [31:0]       pwdata_i  = 32'h0;
  logic [31:0]       prdata_o;
  logic              pready_o;
  logic              pslverr_o;
  logic              busy_o;
  logic [31:0]       rd;
  logic              er;
  int                err_total = 0;
  int                comparisons = 0;
  logic [7:0]        vals [6] = '{8'h00, 8'h01, 8'h10, 8'h80, 8'h81, 8'hFF};

  always #2 clk_sys_i = ~clk_sys_i;

  dfro_top dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .busy_o(busy_o)
  );

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Ready is read as the rising edge wakes us, before that edge's own updates land.
  // Only the watchdog ends a wait for an answer that never comes.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel_i    <= 1'h1;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'h1;
    @(posedge clk_sys_i);
    while (pready_o !== 1'h1) begin
      @(posedge clk_sys_i);
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'h0;
    penable_i <= 1'h0;
  endtask

  task automatic run(input logic [11:0] ma, input logic [7:0] v, input logic [15:0] op,
                     input logic ext);
    int n;
    logic [7:0] r;
    n = 0;
    r = v - 8'h1;
    apb(1'h1, OFS_MEMADDR, {20'h0, ma});
    apb(1'h1, OFS_MEMDATA, {24'h0, v});
    apb(1'h1, OFS_WORK, 32'hA5);
    apb(1'h1, OFS_STATUS, 32'h0);
    apb(1'h1, OFS_OPCODE, {16'h0, op});
    apb(1'h1, OFS_CTRL, {30'h0, ext, 1'h1});
    @(negedge clk_sys_i);
    while (busy_o === 1'h1 && n < 20) begin
      n++;
      @(negedge clk_sys_i);
    end
    chk("busy cycles", 32'(n), 32'h4);
    apb(1'h0, OFS_WORK, 32'h0);
    chk("work", rd, op[OP_DEST] ? 32'hA5 : {24'h0, r});
    apb(1'h0, OFS_MEMDATA, 32'h0);
    chk("memory", rd, {24'h0, op[OP_DEST] ? r : v});
    apb(1'h0, OFS_STATUS, 32'h0);
    chk("flags", rd, {27'h0, r[7], v == 8'h80, v == 8'h01, v[3:0] != 4'h0, v != 8'h0});
  endtask

  task automatic busy_refuse;
    apb(1'h1, OFS_MEMADDR, 32'h240);
    apb(1'h1, OFS_MEMDATA, 32'h9);
    apb(1'h1, OFS_OPCODE, 32'h0540);
    apb(1'h1, OFS_CTRL, 32'h1);
    apb(1'h1, OFS_WORK, 32'h22);
    chk("write while busy", {31'h0, er}, 32'h1);
    repeat (6) @(posedge clk_sys_i);
    apb(1'h0, OFS_WORK, 32'h0);
    chk("work after refusal", rd, 32'h8);
  endtask

  task automatic reset_values;
    apb(1'h0, OFS_OPCODE, 32'h0);
    chk("opcode reset", rd, 32'h0600);
    apb(1'h0, 8'h20, 32'h0);
    chk("unmapped error", {31'h0, er}, 32'h1);
  endtask

  // An opcode outside the decrement family must end after decode and write nothing.
  task automatic bad_opcode;
    int n;
    n = 0;
    apb(1'h1, OFS_MEMADDR, 32'h240);
    apb(1'h1, OFS_MEMDATA, 32'h33);
    apb(1'h1, OFS_STATUS, 32'h0);
    apb(1'h1, OFS_OPCODE, 32'h0B40);
    apb(1'h1, OFS_CTRL, 32'h1);
    @(negedge clk_sys_i);
    while (busy_o === 1'h1 && n < 20) begin
      n++;
      @(negedge clk_sys_i);
    end
    chk("bad opcode busy cycles", 32'(n), 32'h1);
    apb(1'h0, OFS_STATUS, 32'h0);
    chk("bad opcode status", rd, 32'h200);
    apb(1'h0, OFS_MEMDATA, 32'h0);
    chk("bad opcode memory", rd, 32'h33);
  endtask

  // Dropping the clock enable just after start must hold the instruction in its first phase.
  task automatic ce_freeze;
    int n;
    n = 0;
    apb(1'h1, OFS_MEMADDR, 32'h240);
    apb(1'h1, OFS_MEMDATA, 32'h55);
    apb(1'h1, OFS_OPCODE, 32'h0740);
    apb(1'h1, OFS_CTRL, 32'h1);
    ce_i <= 1'h0;
    repeat (10) @(posedge clk_sys_i);
    chk("busy while frozen", {31'h0, busy_o}, 32'h1);
    ce_i <= 1'h1;
    @(posedge clk_sys_i);
    while (busy_o === 1'h1 && n < 20) begin
      n++;
      @(posedge clk_sys_i);
    end
    chk("busy cycles after thaw", 32'(n), 32'h4);
    apb(1'h0, OFS_MEMDATA, 32'h0);
    chk("memory after thaw", rd, 32'h54);
  endtask

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #40000;
    err_total++;
    results();
  end

  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    reset_values();
    apb(1'h1, OFS_BANK, 32'h2);
    foreach (vals[i]) begin
      run(12'h240, vals[i], 16'h0740, 1'h0);
      run(12'h240, vals[i], 16'h0540, 1'h0);
    end
    apb(1'h1, OFS_INDEX, 32'h300);
    run(12'h310, 8'h37, 16'h0610, 1'h1);
    run(12'h35F, 8'h20, 16'h065F, 1'h1);
    run(12'hF60, 8'h37, 16'h0660, 1'h1);
    run(12'h010, 8'h37, 16'h0610, 1'h0);
    bad_opcode();
    ce_freeze();
    busy_refuse();
    results();
  end
endmodule
